// ==== wbrs_pkg.sv ====
/*
  Shared constants and types of the watchdog and bidirectional reset
  sequencer: register map, field positions, keys, timing counts, states.
  Assumes a 100 MHz system clock that also stands for the CPU clock.
*/
package wbrs_pkg;

  // Clock period and CPU clock half-period, in ns.
  localparam int CLK_NS = 10;
  localparam int TCL_NS = 5;

  // Internal reset sequence length, 1024 half-periods.
  localparam int SEQ_TCL = 1024;
  localparam int SEQ_CYC = (SEQ_TCL * TCL_NS + CLK_NS - 1) / CLK_NS;
  // Sample point after the sequence, 8 half-periods.
  localparam int SAMPLE_TCL = 8;
  localparam int SAMPLE_CYC = (SAMPLE_TCL * TCL_NS + CLK_NS - 1) / CLK_NS;
  // Least low time of a short hardware reset, 4 half-periods.
  localparam int SHORT_TCL = 4;
  localparam int SHORT_CYC = (SHORT_TCL * TCL_NS + CLK_NS - 1) / CLK_NS;
  // Flash initialisation time, well above the longest filter delay.
  localparam int FLASH_NS = 1000;
  localparam int FLASH_CYC = (FLASH_NS + CLK_NS - 1) / CLK_NS;

  // Register byte offsets.
  localparam logic [7:0] OFS_SYSCFG = 8'h00;
  localparam logic [7:0] OFS_WDTCTL = 8'h04;
  localparam logic [7:0] OFS_WDTSVC = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_WDTCNT = 8'h14;

  // Field positions.
  localparam int SYSCFG_BIDIR_BIT = 3;
  localparam int SYSCFG_PWDUP_BIT = 4;
  localparam int WDTCTL_DIS_BIT = 16;
  localparam int STATUS_INIT_BIT = 4;

  // Command keys, values arbitrary.
  localparam logic [7:0] KEY_END_OF_INIT_INSTRUCTION = 8'h4e;
  localparam logic [7:0] KEY_SOFTWARE_RESET_INSTRUCTION = 8'h5a;
  localparam logic [7:0] KEY_SERVICE = 8'ha5;

  // Reset values.
  localparam logic [15:0] WDT_RELOAD_RST = 16'h0000;
  localparam logic [15:0] CFG_LATCH_RST = 16'hffff;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Reset source flags.
  typedef struct packed {
    logic long_hw;
    logic short_hw;
    logic sw;
    logic wdt;
  } wbrs_flags_s;

  localparam wbrs_flags_s FLG_NONE = '{1'b0, 1'b0, 1'b0, 1'b0};
  localparam wbrs_flags_s FLG_LONG = '{1'b1, 1'b1, 1'b1, 1'b0};
  localparam wbrs_flags_s FLG_SHORT = '{1'b0, 1'b1, 1'b1, 1'b0};
  localparam wbrs_flags_s FLG_SW = '{1'b0, 1'b0, 1'b1, 1'b0};
  localparam wbrs_flags_s FLG_WDT = '{1'b0, 1'b0, 1'b1, 1'b1};

  // Sequencer states.
  typedef enum logic [5:0] {
    ST_RUN = 6'b000001,
    ST_BUSW = 6'b000010,
    ST_SEQ = 6'b000100,
    ST_FLASH = 6'b001000,
    ST_POST = 6'b010000,
    ST_HOLD = 6'b100000
  } wbrs_state_e;

  // Reset sources.
  typedef enum logic [2:0] {
    SRC_HW = 3'b001,
    SRC_SW = 3'b010,
    SRC_WDT = 3'b100
  } wbrs_src_e;

endpackage

// ==== wbrs_top.sv ====
/*
  Watchdog and bidirectional reset sequencer with an AXI4-Lite register
  slave. Assumes all pin inputs are synchronous to SYS_CLK and that the
  bench resolves the open-drain reset input wire from its enable.
*/
// Functional notes
// - Unserviced enabled watchdog overflows and starts reset.
// - Watchdog lets bus cycle finish when allowed.
// - Ready high after waits aborts cycle first.
// - Watchdog end latches bits 12:8, sets 7:2.
// - Watchdog reset always synchronous, even with powerdown pin low.
// - Bidir watchdog drives pin only if powerdown high.
// - Reset output low from start until end-of-init.
// - Bidir enable bit 3, writable only before init end.
// - Bidir pulls reset pin low whole sequence.
// - Short bidir hardware reset sampled 8 CLOCK_HALF_PERIOD after.
// - Low 4 CLOCK_HALF_PERIOD after soft exit gives hardware reset.
// - Powerdown low releases pin in software/watchdog resets, sequence still completes.
// - Every reset sequence clears bidir enable.
// - Degenerated reset flags replace software/watchdog flags.
// - Long degeneration needs external party holding pin low.
// - Internal flash extends reset beyond filter delay.
// - Pull-up config bit enables pull-up at sequence end.
// - Pull-down on whenever reset input pin low.
// - Powerdown low with reset asserted forces async reset.
// - Software reset command starts sequence only from run state.
`timescale 1ns/1ns
module wbrs_top #(
  parameter int FILT_DLY = 10
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RESET_IN_I,
  output logic RESET_IN_O,
  output logic RESET_IN_OE_N,
  input wire logic PD_RESET_PIN,
  output logic PD_PULLUP_EN,
  output logic PD_PULLDOWN_EN,
  output logic RESET_OUT_N,
  output logic CORE_RESET_N,
  input wire logic EXT_ACCESS_PIN,
  input wire logic EXT_BUS_BUSY,
  input wire logic EXT_BUS_USES_READY,
  input wire logic EXT_WAIT_DONE,
  input wire logic EXT_READY_N,
  output logic BUS_ABORT,
  input wire logic [15:0] CFG_PORT,
  output logic [15:0] CFG_LATCHED
);

  // Sequencer state and its counters.
  wbrs_pkg::wbrs_state_e state_ff;
  wbrs_pkg::wbrs_src_e src_ff;
  logic [11:0] cnt_ff; // Cycle count within the current phase.
  logic [3:0] low_ff; // Run of low filtered-input cycles.
  wbrs_pkg::wbrs_flags_s flags_ff; // Last reset source.
  logic init_ff; // High until the end-of-init command.
  logic async_ff; // Hardware reset has turned asynchronous.
  logic drive_ff; // Reset input pin is being pulled low.

  // Registers.
  logic bidir_en_ff;
  logic pwd_cfg_ff;
  logic wdt_dis_ff;
  logic [15:0] reload_ff;
  logic [15:0] wdt_cnt_ff;

  // Bus slave state.
  logic aw_have_ff;
  logic w_have_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [31:0] rd_data;
  logic rd_err;
  logic wr_do;

  // Filter delay line; a reset value of ones means a released pin.
  logic [FILT_DLY-1:0] filt_ff;
  logic filt_low;

  // Decoded events.
  logic wdt_ovf;
  logic sw_cmd;
  logic end_of_init_instruction_cmd;
  logic svc_cmd;
  logic bus_abort_c;
  logic start_go;
  wbrs_pkg::wbrs_src_e start_src;
  wbrs_pkg::wbrs_flags_s start_flags;
  logic phase_end;
  logic finish;

  // The analogue filter is modelled as a plain shift delay.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      filt_ff <= '1;
    end else begin
      filt_ff <= {filt_ff[FILT_DLY-2:0], RESET_IN_I};
    end
  end
  assign filt_low = !filt_ff[FILT_DLY-1];

  // Write-side decodes; keys only count with byte lane 0 enabled.
  assign wr_do = aw_have_ff && w_have_ff && !S_AXI_BVALID;
  assign sw_cmd = wr_do && (awaddr_ff == wbrs_pkg::OFS_CMD) &&
                  wstrb_ff[0] && (wdata_ff[7:0] == wbrs_pkg::KEY_SOFTWARE_RESET_INSTRUCTION);
  assign end_of_init_instruction_cmd = wr_do && (awaddr_ff == wbrs_pkg::OFS_CMD) &&
                     wstrb_ff[0] && init_ff &&
                     (wdata_ff[7:0] == wbrs_pkg::KEY_END_OF_INIT_INSTRUCTION);
  assign svc_cmd = wr_do && (awaddr_ff == wbrs_pkg::OFS_WDTSVC) &&
                   wstrb_ff[0] && (wdata_ff[7:0] == wbrs_pkg::KEY_SERVICE);

  // The watchdog only overflows while running and not disabled.
  assign wdt_ovf = (state_ff == wbrs_pkg::ST_RUN) && !wdt_dis_ff &&
                   (wdt_cnt_ff == 16'hffff);

  // A watchdog reset aborts a cycle whose ready is still high after
  // the wait states; otherwise it waits for the cycle to end.
  assign bus_abort_c = (state_ff == wbrs_pkg::ST_BUSW) && EXT_BUS_BUSY &&
                       EXT_BUS_USES_READY && EXT_WAIT_DONE &&
                       EXT_READY_N;

  // End of the counted phase in the sequence, flash and post states.
  always_comb begin
    phase_end = 1'b0;
    case (state_ff)
      wbrs_pkg::ST_SEQ: phase_end = cnt_ff == 12'(wbrs_pkg::SEQ_CYC - 1);
      wbrs_pkg::ST_FLASH:
        phase_end = cnt_ff == 12'(wbrs_pkg::FLASH_CYC - 1);
      wbrs_pkg::ST_POST:
        phase_end = cnt_ff == 12'(wbrs_pkg::SAMPLE_CYC - 1);
      default: phase_end = 1'b0;
    endcase
  end

  // Start of a new sequence, by priority: asynchronous hardware,
  // hardware, watchdog, software, and degeneration after exit.
  always_comb begin
    start_go = 1'b0;
    start_src = wbrs_pkg::SRC_HW;
    start_flags = wbrs_pkg::FLG_NONE;
    case (state_ff)
      wbrs_pkg::ST_RUN: begin
        if (filt_low && !PD_RESET_PIN) begin
          start_go = 1'b1;
          start_flags = wbrs_pkg::FLG_LONG;
        end else if (filt_low &&
                     low_ff >= 4'(wbrs_pkg::SHORT_CYC - 1)) begin
          start_go = 1'b1;
          start_flags = wbrs_pkg::FLG_SHORT;
        end else if (wdt_ovf && !EXT_BUS_BUSY) begin
          start_go = 1'b1;
          start_src = wbrs_pkg::SRC_WDT;
          start_flags = wbrs_pkg::FLG_WDT;
        end else if (sw_cmd) begin
          start_go = 1'b1;
          start_src = wbrs_pkg::SRC_SW;
          start_flags = wbrs_pkg::FLG_SW;
        end
      end
      wbrs_pkg::ST_BUSW: begin
        if (!EXT_BUS_BUSY || bus_abort_c) begin
          start_go = 1'b1;
          start_src = wbrs_pkg::SRC_WDT;
          start_flags = wbrs_pkg::FLG_WDT;
        end
      end
      wbrs_pkg::ST_POST: begin
        // A pin still low after a soft exit becomes a hardware reset.
        if (phase_end && src_ff != wbrs_pkg::SRC_HW && filt_low &&
            low_ff >= 4'(wbrs_pkg::SHORT_CYC - 1)) begin
          start_go = 1'b1;
          start_flags = wbrs_pkg::FLG_SHORT;
        end
      end
      default: start_go = 1'b0;
    endcase
  end

  // A sequence finishes after the post phase or the long hold.
  assign finish = (!start_go && phase_end &&
                   state_ff == wbrs_pkg::ST_POST &&
                   (src_ff != wbrs_pkg::SRC_HW || !filt_low)) ||
                  (state_ff == wbrs_pkg::ST_HOLD && !filt_low);

  // Main sequencer.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_ff <= wbrs_pkg::ST_RUN;
      src_ff <= wbrs_pkg::SRC_HW;
      cnt_ff <= '0;
      async_ff <= 1'b0;
    end else if (start_go) begin
      state_ff <= wbrs_pkg::ST_SEQ;
      src_ff <= start_src;
      cnt_ff <= '0;
      async_ff <= start_flags.long_hw && start_src == wbrs_pkg::SRC_HW;
    end else begin
      cnt_ff <= cnt_ff + 12'h001;
      case (state_ff)
        wbrs_pkg::ST_RUN: begin
          if (wdt_ovf) begin
            state_ff <= wbrs_pkg::ST_BUSW;
          end
        end
        wbrs_pkg::ST_SEQ: begin
          // Powerdown pin is looked at only for hardware sources.
          if (src_ff == wbrs_pkg::SRC_HW && filt_low && !PD_RESET_PIN) begin
            async_ff <= 1'b1;
          end
          if (phase_end) begin
            cnt_ff <= '0;
            state_ff <= EXT_ACCESS_PIN ? wbrs_pkg::ST_FLASH :
                        wbrs_pkg::ST_POST;
          end
        end
        wbrs_pkg::ST_FLASH: begin
          if (phase_end) begin
            cnt_ff <= '0;
            state_ff <= wbrs_pkg::ST_POST;
          end
        end
        wbrs_pkg::ST_POST: begin
          // Hardware reset sampled low turns long and waits.
          if (phase_end) begin
            state_ff <= finish ? wbrs_pkg::ST_RUN :
                        wbrs_pkg::ST_HOLD;
          end
        end
        wbrs_pkg::ST_HOLD: begin
          if (finish) begin
            state_ff <= wbrs_pkg::ST_RUN;
          end
        end
        default: state_ff <= wbrs_pkg::ST_RUN;
      endcase
    end
  end

  // Run of low filtered samples, counted in run and post phases.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      low_ff <= '0;
    end else if (!filt_low || start_go) begin
      low_ff <= '0;
    end else if ((state_ff == wbrs_pkg::ST_RUN ||
                  state_ff == wbrs_pkg::ST_POST) && low_ff != 4'hf) begin
      low_ff <= low_ff + 4'h1;
    end
  end

  // Reset source flags; a new source replaces the old one.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      flags_ff <= wbrs_pkg::FLG_LONG;
    end else if (start_go) begin
      flags_ff <= start_flags;
    end else if (state_ff == wbrs_pkg::ST_POST && phase_end &&
                 !finish) begin
      flags_ff <= wbrs_pkg::FLG_LONG;
    end else if (state_ff == wbrs_pkg::ST_SEQ && async_ff) begin
      flags_ff <= wbrs_pkg::FLG_LONG;
    end
  end

  // Open-drain drive of the reset input pin. The enable bit is read
  // before it is cleared by the same start.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      drive_ff <= 1'b0;
    end else if (start_go) begin
      drive_ff <= bidir_en_ff &&
                  (start_src == wbrs_pkg::SRC_HW || PD_RESET_PIN);
    end else if (state_ff == wbrs_pkg::ST_SEQ && phase_end) begin
      drive_ff <= 1'b0;
    end else if (src_ff != wbrs_pkg::SRC_HW && !PD_RESET_PIN) begin
      drive_ff <= 1'b0;
    end
  end

  // Pin outputs, all from flops.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RESET_IN_O <= 1'b0;
      RESET_IN_OE_N <= 1'b1;
      PD_PULLDOWN_EN <= 1'b0;
      CORE_RESET_N <= 1'b0;
      BUS_ABORT <= 1'b0;
    end else begin
      RESET_IN_O <= 1'b0;
      RESET_IN_OE_N <= !drive_ff;
      PD_PULLDOWN_EN <= !RESET_IN_I;
      CORE_RESET_N <= (state_ff == wbrs_pkg::ST_RUN ||
                       state_ff == wbrs_pkg::ST_BUSW ||
                       (state_ff == wbrs_pkg::ST_POST &&
                        src_ff != wbrs_pkg::SRC_HW)) && !start_go;
      BUS_ABORT <= bus_abort_c;
    end
  end

  // Initialisation phase and reset output pin.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      init_ff <= 1'b1;
      RESET_OUT_N <= 1'b0;
    end else if (start_go) begin
      init_ff <= 1'b1;
      RESET_OUT_N <= 1'b0;
    end else if (end_of_init_instruction_cmd && state_ff == wbrs_pkg::ST_RUN) begin
      init_ff <= 1'b0;
      RESET_OUT_N <= 1'b1;
    end
  end

  // Configuration latch and powerdown pull-up at sequence end.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      CFG_LATCHED <= wbrs_pkg::CFG_LATCH_RST;
      PD_PULLUP_EN <= 1'b0;
    end else if (start_go) begin
      PD_PULLUP_EN <= 1'b0;
    end else if (finish) begin
      PD_PULLUP_EN <= pwd_cfg_ff;
      if (src_ff == wbrs_pkg::SRC_HW) begin
        CFG_LATCHED <= CFG_PORT;
      end else begin
        CFG_LATCHED <= {CFG_LATCHED[15:13], CFG_PORT[12:8], 6'h3f,
                        CFG_LATCHED[1:0]};
      end
    end
  end

  // Watchdog counter; service reloads it, a sequence restarts it.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wdt_cnt_ff <= wbrs_pkg::WDT_RELOAD_RST;
    end else if (start_go || svc_cmd) begin
      wdt_cnt_ff <= reload_ff;
    end else if (state_ff == wbrs_pkg::ST_RUN && !wdt_dis_ff) begin
      wdt_cnt_ff <= wdt_cnt_ff + 16'h0001;
    end
  end

  // Software registers. The start clear comes last so that a reset
  // sequence always leaves the enable bit cleared.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bidir_en_ff <= 1'b0;
      pwd_cfg_ff <= 1'b0;
      wdt_dis_ff <= 1'b0;
      reload_ff <= wbrs_pkg::WDT_RELOAD_RST;
    end else begin
      if (wr_do && awaddr_ff == wbrs_pkg::OFS_SYSCFG && wstrb_ff[0]) begin
        pwd_cfg_ff <= wdata_ff[wbrs_pkg::SYSCFG_PWDUP_BIT];
        if (init_ff) begin
          bidir_en_ff <= wdata_ff[wbrs_pkg::SYSCFG_BIDIR_BIT];
        end
      end
      if (wr_do && awaddr_ff == wbrs_pkg::OFS_WDTCTL) begin
        if (wstrb_ff[0]) begin
          reload_ff[7:0] <= wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
          reload_ff[15:8] <= wdata_ff[15:8];
        end
        // The watchdog can only be switched off during initialisation.
        if (wstrb_ff[2] && init_ff) begin
          wdt_dis_ff <= wdata_ff[wbrs_pkg::WDTCTL_DIS_BIT];
        end
      end
      if (start_go) begin
        bidir_en_ff <= 1'b0;
        wdt_dis_ff <= 1'b0;
      end
    end
  end

  // Write address and data channels, taken in either order.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (wr_do) begin
        aw_have_ff <= 1'b0;
      end else if (!aw_have_ff && !S_AXI_BVALID) begin
        S_AXI_AWREADY <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end else if (wr_do) begin
        w_have_ff <= 1'b0;
      end else if (!w_have_ff && !S_AXI_BVALID) begin
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= wbrs_pkg::RESP_OKAY;
    end else if (wr_do) begin
      S_AXI_BVALID <= 1'b1;
      case (awaddr_ff)
        wbrs_pkg::OFS_SYSCFG, wbrs_pkg::OFS_WDTCTL,
        wbrs_pkg::OFS_WDTSVC, wbrs_pkg::OFS_CMD:
          S_AXI_BRESP <= wbrs_pkg::RESP_OKAY;
        default: S_AXI_BRESP <= wbrs_pkg::RESP_SLVERR;
      endcase
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read data multiplexer.
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    case (S_AXI_ARADDR)
      wbrs_pkg::OFS_SYSCFG: begin
        rd_data[wbrs_pkg::SYSCFG_BIDIR_BIT] = bidir_en_ff;
        rd_data[wbrs_pkg::SYSCFG_PWDUP_BIT] = pwd_cfg_ff;
      end
      wbrs_pkg::OFS_WDTCTL: begin
        rd_data[15:0] = reload_ff;
        rd_data[wbrs_pkg::WDTCTL_DIS_BIT] = wdt_dis_ff;
      end
      wbrs_pkg::OFS_WDTSVC, wbrs_pkg::OFS_CMD: rd_data = '0;
      wbrs_pkg::OFS_STATUS: begin
        rd_data[3:0] = flags_ff;
        rd_data[wbrs_pkg::STATUS_INIT_BIT] = init_ff;
        rd_data[31:16] = CFG_LATCHED;
      end
      wbrs_pkg::OFS_WDTCNT: rd_data[15:0] = wdt_cnt_ff;
      default: rd_err = 1'b1;
    endcase
  end

  // Read channel: one read at a time, answered the cycle after.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= wbrs_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_err ? wbrs_pkg::RESP_SLVERR : wbrs_pkg::RESP_OKAY;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end else if (!S_AXI_RVALID) begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // wbrs_top

// ==== wbrs_checker.sv ====
/*
  Timing checks on the reset sequencer's pins and register bus.
  Assumes binding to the top module, with one clock for all of them.
*/
`timescale 1ns/1ns
module wbrs_checker (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic RESET_IN_I,
  input wire logic RESET_IN_O,
  input wire logic RESET_IN_OE_N,
  input wire logic PD_PULLDOWN_EN,
  input wire logic RESET_OUT_N,
  input wire logic CORE_RESET_N,
  input wire logic BUS_ABORT,
  input wire logic EXT_BUS_BUSY,
  input wire logic EXT_READY_N
);
  // One domain, so clock and reset mask are declared once.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // The first edge after release still sees reset values, hence $past.
  pulldown_follow_a: assert property ($past(RST_N) |->
    PD_PULLDOWN_EN == !$past(RESET_IN_I)) else $error("pull-down late");
  abort_cause_a: assert property (BUS_ABORT |->
    $past(EXT_BUS_BUSY && EXT_READY_N)) else $error("abort uncaused");
  abort_pulse_a: assert property (BUS_ABORT |=> !BUS_ABORT)
    else $error("abort too long");
  reset_output_pin_start_a: assert property ($fell(CORE_RESET_N) |->
    !RESET_OUT_N) else $error("reset output high at start");
  reset_output_pin_hold_a: assert property (!CORE_RESET_N |-> !RESET_OUT_N)
    else $error("reset output high in sequence");
  drive_low_a: assert property (!RESET_IN_OE_N |->
    !RESET_IN_O && !RESET_OUT_N) else $error("open drain wrong");
  bvalid_lat_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |-> ##1 !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer late");
  bclear_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
    !S_AXI_BVALID) else $error("write answer stuck");
  rvalid_lat_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID) else $error("read answer late");
endmodule // wbrs_checker
bind wbrs_top wbrs_checker chk_u (.*);

// ==== wbrs_partner.sv ====
/*
  Far side of the reset input wire: pull-up, a manual reset source and
  a slow external driver. Assumes the device only ever drives it low.
*/
`timescale 1ns/1ns
module wbrs_partner (
  input wire logic clk,
  input wire logic dev_o,
  input wire logic oe_n,
  input wire logic man_low,
  input wire logic [7:0] hold,
  output logic lvl
);
  logic [7:0] cnt_ff = 8'h00; // Cycles the outside keeps pulling low.
  logic oe_q_ff = 1'b1; // Last device enable, for release detection.
  // An outside driver that lags the device's release, to inject resets.
  always_ff @(posedge clk) begin
    oe_q_ff <= oe_n;
    if (oe_n && !oe_q_ff) begin
      cnt_ff <= hold;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  // Wired-and with a pull-up: any enabled driver wins over the resistor.
  // The outside driver takes over in the release cycle, so no glitch.
  assign lvl = !oe_n ? dev_o :
               !(man_low || cnt_ff != 8'h00 || !oe_q_ff);
endmodule // wbrs_partner

// ==== wbrs_tb_top.sv ====
/*
  Self-checking bench of the reset sequencer: bus tasks and scenarios.
  Assumes the partner model resolves the reset wire for the design.
*/
`timescale 1ns/1ns
module wbrs_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, hold = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, man_low = 1'b0, pd = 1'b1, ea = 1'b0;
  logic busy = 1'b0, rdyn = 1'b0, pcfg, seen_oe, seen_ab;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [15:0] cfg = 16'h0, cfg_l, exp_cfg;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, dev_o, oe_n;
  logic pu, pdn, rout_n, core_n, abort, lvl;
  int n_errors = 0, n_compared = 0;
  initial forever #5 clk = ~clk;
  // Filter shortened to three cycles; the bus-wait inputs share busy.
  wbrs_top #(.FILT_DLY(3)) dut_u (.SYS_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .RESET_IN_I(lvl),
    .RESET_IN_O(dev_o), .RESET_IN_OE_N(oe_n), .PD_RESET_PIN(pd),
    .PD_PULLUP_EN(pu), .PD_PULLDOWN_EN(pdn), .RESET_OUT_N(rout_n),
    .CORE_RESET_N(core_n), .EXT_ACCESS_PIN(ea), .EXT_BUS_BUSY(busy),
    .EXT_BUS_USES_READY(busy), .EXT_WAIT_DONE(busy), .EXT_READY_N(rdyn),
    .BUS_ABORT(abort), .CFG_PORT(cfg), .CFG_LATCHED(cfg_l));
  wbrs_partner far_u (.clk(clk), .dev_o(dev_o), .oe_n(oe_n),
    .man_low(man_low), .hold(hold), .lvl(lvl));
  task automatic print_verdict();
    $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Readies are sampled at the falling edge, so the value is settled.
  // The loop ends on the sampled answer, not on the pending strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [2:0] t;
    t = 3'b000;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 64 && !t[0]; k++) begin
      @(negedge clk);
      t = {awready, wready, bvalid};
      if (bvalid) r = bresp;
      @(posedge clk);
      if (t[2]) awvalid <= 1'b0;
      if (t[1]) wvalid <= 1'b0;
      if (t[0]) bready <= 1'b0;
    end
    if (!t[0]) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic [1:0] t;
    t = 2'b00;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 64 && !t[0]; k++) begin
      @(negedge clk);
      t = {arready, rvalid};
      if (rvalid) begin
        d = rdata;
        r = rresp;
      end
      @(posedge clk);
      if (t[1]) arvalid <= 1'b0;
      if (t[0]) rready <= 1'b0;
    end
    if (!t[0]) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // Waits out a whole reset episode; a degenerated one restarts count.
  task automatic settle();
    int s;
    s = 0;
    seen_oe = 1'b0;
    seen_ab = 1'b0;
    for (int k = 0; k < 4000 && s < 40; k++) begin
      @(negedge clk);
      seen_oe |= !oe_n;
      seen_ab |= abort;
      s = (core_n && k > 600) ? s + 1 : 0;
    end
    if (s < 40) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic stat(input wbrs_pkg::wbrs_flags_s f);
    rd(wbrs_pkg::OFS_STATUS);
    chk(d & 32'hffff_001f, {exp_cfg, 11'h000, 1'b1, f});
    chk(cfg_l, exp_cfg);
  endtask
  function automatic logic [15:0] soft_cfg(input logic [15:0] o);
    return {o[15:13], cfg[12:8], 6'h3f, o[1:0]};
  endfunction
  initial begin
    void'($urandom(32'hb51c));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    exp_cfg = 16'hffff;
    // Bidirectional software resets, with a lagging outside driver.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      ea <= i[0];
      cfg <= 16'($urandom);
      hold <= 8'h14;
      pcfg = 1'($urandom);
      wr(wbrs_pkg::OFS_SYSCFG, {27'h0, pcfg, 4'h8});
      wr(wbrs_pkg::OFS_CMD, {24'h0, wbrs_pkg::KEY_SOFTWARE_RESET_INSTRUCTION});
      settle();
      exp_cfg = i ? soft_cfg(exp_cfg) : cfg;
      chk(seen_oe, 1);
      stat(i ? wbrs_pkg::FLG_SW : wbrs_pkg::FLG_SHORT);
      chk(pu, pcfg);
      rd(wbrs_pkg::OFS_SYSCFG);
      chk(d[3], 0);
      chk(rout_n, 0);
    end
    // Watchdog overflow over a running bus cycle that is not ready.
    @(posedge clk);
    pd <= 1'b0;
    busy <= 1'b1;
    rdyn <= 1'b1;
    hold <= 8'h00;
    wr(wbrs_pkg::OFS_SYSCFG, 32'h8);
    wr(wbrs_pkg::OFS_WDTCTL, 32'h0000_fe00);
    wr(wbrs_pkg::OFS_WDTSVC, {24'h0, wbrs_pkg::KEY_SERVICE});
    settle();
    exp_cfg = soft_cfg(exp_cfg);
    chk(seen_ab, 1);
    chk(seen_oe, 0);
    stat(wbrs_pkg::FLG_WDT);
    // Watchdog again over a cycle that ends with ready active: it waits.
    @(posedge clk);
    rdyn <= 1'b0;
    repeat (600) @(negedge clk);
    chk(core_n, 1);
    @(posedge clk);
    busy <= 1'b0;
    settle();
    chk(seen_ab, 0);
    stat(wbrs_pkg::FLG_WDT);
    @(posedge clk);
    busy <= 1'b0;
    pd <= 1'b1;
    wr(wbrs_pkg::OFS_CMD, {24'h0, wbrs_pkg::KEY_END_OF_INIT_INSTRUCTION});
    chk(r, wbrs_pkg::RESP_OKAY);
    wr(wbrs_pkg::OFS_SYSCFG, 32'h8);
    rd(wbrs_pkg::OFS_SYSCFG);
    chk(d[3], 0);
    chk(rout_n, 1);
    rd(8'h18);
    chk(r, wbrs_pkg::RESP_SLVERR);
    // Outside reset pulses, first synchronous, then with the pin low.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pd <= !i[0];
      man_low <= 1'b1;
      repeat (10) @(posedge clk);
      man_low <= 1'b0;
      settle();
      exp_cfg = cfg;
      stat(i ? wbrs_pkg::FLG_LONG : wbrs_pkg::FLG_SHORT);
    end
    print_verdict();
  end
endmodule // wbrs_tb_top
